/* sfr_pkg.sv */
/*
  Shared constants, types and decode functions for the serial flash read
  engine: opcodes, phase lengths, host register map and timing counts.
  Assumes both ends and the bench import it whole.
*/
package sfr_pkg;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_NORM  = 8'h03;
  localparam logic [7:0] OP_NORM4 = 8'h13;
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_FAST4 = 8'h0C;
  localparam logic [7:0] OP_DIO   = 8'hBB;
  localparam logic [7:0] OP_DIO4  = 8'hBC;
  localparam logic [7:0] OP_QIO   = 8'hEB;
  localparam logic [7:0] OP_UID   = 8'h4B;
  localparam logic [7:0] OP_IROW  = 8'h68;

  // ----------------------------------------
  // phase lengths and mode byte
  // ----------------------------------------
  localparam logic [5:0] CMD_BITS    = 6'h08;
  localparam logic [5:0] ADDR3_BITS  = 6'h18;
  localparam logic [5:0] ADDR4_BITS  = 6'h20;
  localparam logic [5:0] MODE_CYC    = 6'h04;
  localparam logic [5:0] MODE_DRV    = 6'h02;
  localparam logic [3:0] CONT_NIBBLE = 4'hA;
  localparam logic [3:0] DUM_FAST    = 4'h8;
  localparam logic [3:0] DUM_QUAD    = 4'h6;
  localparam logic [3:0] DUM_DUAL    = 4'h4;

  // ----------------------------------------
  // host register map (byte offsets) and fields
  // ----------------------------------------
  localparam logic [4:0]  REG_CTRL  = 5'h00;
  localparam logic [4:0]  REG_CFG   = 5'h04;
  localparam logic [4:0]  REG_ADDR  = 5'h08;
  localparam logic [4:0]  REG_STAT  = 5'h0C;
  localparam logic [4:0]  REG_RDATA = 5'h10;
  localparam int          CTRL_GO   = 0;
  localparam int          CTRL_HOLD = 1;
  localparam int          CFG_QUAD  = 8;
  localparam int          CFG_EXT   = 9;
  localparam int          CFG_SKIP  = 10;
  localparam int          CFG_DUM   = 12;
  localparam int          CFG_MODE  = 16;
  localparam int          CFG_NB    = 24;
  localparam logic [31:0] CFG_RESET = 32'h0100_8003;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_NS       = 25;
  localparam int         SCK_HALF_NS  = 200;
  localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_NS / CLK_NS);

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_CMD   = 6'h02,
    S_ADDR  = 6'h04,
    S_DUMMY = 6'h08,
    S_DATA  = 6'h10,
    S_SKIP  = 6'h20
  } sfr_state_t;

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic logic sfr_supported(input logic [7:0] op, input logic quad);
    if (quad)
      return op inside {OP_FAST, OP_FAST4, OP_QIO, OP_UID, OP_IROW};
    return op inside {OP_NORM, OP_NORM4, OP_FAST, OP_FAST4, OP_DIO, OP_DIO4};
  endfunction

  function automatic logic [2:0] sfr_lanes(input logic [7:0] op, input logic quad);
    if (quad)
      return 3'h4;
    return (op == OP_DIO || op == OP_DIO4) ? 3'h2 : 3'h1;
  endfunction

  function automatic logic sfr_addr4(input logic [7:0] op, input logic quad, input logic ext);
    if (op inside {OP_NORM4, OP_FAST4, OP_DIO4})
      return 1'b1;
    if (quad && (op == OP_UID || op == OP_IROW))
      return 1'b0;
    return ext;
  endfunction

  function automatic logic [31:0] sfr_shift(input logic [31:0] v, input logic [3:0] d, input logic [2:0] w);
    case (w)
      3'h1:    return {v[30:0], d[0]};
      3'h2:    return {v[29:0], d[1:0]};
      default: return {v[27:0], d};
    endcase
  endfunction

endpackage

/* sfr_if.sv */
/*
  Link between flash host and flash device: chip select, serial clock,
  pause line and four shared data lines. Assumes each end drives a line
  only with its enable high; an undriven line reads as pulled up.
*/
`timescale 1ns/10ps
interface sfr_if;
  logic       sck;
  logic       cs_n;
  logic       hold_n;
  logic [3:0] h_o;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  logic [3:0] io;

  // resolved line level, host first, else device, else pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = h_oe[i] ? h_o[i] : (d_oe[i] ? d_o[i] : 1'b1);
    end
  end

  modport host (output sck, output cs_n, output hold_n, output h_o, output h_oe, input io);
  modport dev (input sck, input cs_n, input hold_n, input io, output d_o, output d_oe);
endinterface

/* sfr_dev.sv */
/*
  Flash device end of the read engine: decodes normal, fast, four-wire
  and dual I/O reads, streams array bytes, handles pause and continuous
  read. Assumes a byte array outside answering mem_rdata from mem_addr
  within two clocks, and link pins asynchronous to clock.
*/
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module sfr_dev
  import sfr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  sfr_if.dev               bus,
  input  wire logic        write_in_progress_flag,
  input  wire logic        ext_addr_in,
  input  wire logic        quad_mode_in,
  input  wire logic        qe,
  input  wire logic        dtr_mode,
  input  wire logic        hold_pin_reset,
  input  wire logic [3:0]  dummy_fast,
  input  wire logic [3:0]  dummy_quad,
  input  wire logic [3:0]  dummy_dual,
  output logic      [26:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  output logic             cont_read,
  output logic             busy
);

  sfr_state_t  state_reg;
  logic [2:0]  sck_p;
  logic [2:0]  cs_p;
  logic [2:0]  hold_p;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic        paused_reg;
  logic        ext_reg;
  logic        quad_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] sh_reg;
  logic [7:0]  op_reg;
  logic [2:0]  lanes_reg;
  logic        a4_reg;
  logic [3:0]  dum_reg;
  logic [7:0]  mode_reg;
  logic [26:0] addr_reg;
  logic        cont_reg;
  logic [7:0]  dsh_reg;
  logic [2:0]  dcnt_reg;
  logic        started_reg;
  logic [3:0]  out_reg;
  logic [3:0]  oe_reg;
  logic        sel;
  logic        rise;
  logic        fall;
  logic        go_rise;
  logic        go_fall;
  logic        hold_en;
  logic        dio;
  logic [31:0] sh_next;
  logic [5:0]  cnt_step;
  logic [7:0]  mode_next;
  logic [7:0]  cur_byte;
  logic [3:0]  lane_mask;

  // ----------------------------------------
  // pin synchronisers and edge finders
  // ----------------------------------------
  // two flops on every pin, third stage only for edge finding
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_p  <= 3'h0;
      cs_p   <= 3'h7;
      hold_p <= 3'h7;
      io_s1  <= 4'h0;
      io_s2  <= 4'h0;
    end else begin
      sck_p  <= {sck_p[1:0], bus.sck};
      cs_p   <= {cs_p[1:0], bus.cs_n};
      hold_p <= {hold_p[1:0], bus.hold_n};
      io_s1  <= bus.io;
      io_s2  <= io_s1;
    end
  end

  assign sel      = ~cs_p[1];
  assign rise     = sck_p[1] & ~sck_p[2];
  assign fall     = ~sck_p[1] & sck_p[2];
  assign hold_en  = ~(qe | dtr_mode | hold_pin_reset);
  assign go_rise  = rise & ~paused_reg;
  assign go_fall  = fall & ~paused_reg;
  assign dio      = (op_reg == OP_DIO) || (op_reg == OP_DIO4);
  assign sh_next  = sfr_shift(sh_reg, io_s2, lanes_reg);
  assign cnt_step = cnt_reg + {3'h0, lanes_reg};
  assign mode_next = {mode_reg[5:0], io_s2[1:0]};
  assign cur_byte = (dcnt_reg == 3'h0) ? mem_rdata : dsh_reg;
  assign lane_mask = (lanes_reg == 3'h1) ? 4'h2 : ((lanes_reg == 3'h2) ? 4'h3 : 4'hF);

  // ----------------------------------------
  // pause tracking
  // ----------------------------------------
  // hold edges only count while sck is low and a sequence is underway
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      paused_reg <= 1'b0;
    end else if (!sel || !hold_en) begin
      paused_reg <= 1'b0;
    end else if (!hold_p[1] && hold_p[2] && !sck_p[1] && state_reg != S_IDLE) begin
      paused_reg <= 1'b1;
    end else if (hold_p[1] && !hold_p[2] && !sck_p[1]) begin
      paused_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // configuration capture
  // ----------------------------------------
  // settings follow the inputs only while deselected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_reg  <= 1'b0;
      quad_reg <= 1'b0;
    end else if (!sel) begin
      ext_reg  <= ext_addr_in;
      quad_reg <= quad_mode_in;
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  // phases advance on rising sck, address counter on byte loads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 6'h00;
      sh_reg    <= 32'h0000_0000;
      op_reg    <= 8'h00;
      lanes_reg <= 3'h1;
      a4_reg    <= 1'b0;
      dum_reg   <= 4'h0;
      mode_reg  <= 8'h00;
      addr_reg  <= 27'h000_0000;
      cont_reg  <= 1'b0;
    end else if (!sel) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 6'h00;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          sh_reg <= 32'h0000_0000;
          if (cont_reg && write_in_progress_flag) begin
            state_reg <= S_SKIP;
          end else if (cont_reg) begin
            state_reg <= S_ADDR;
            lanes_reg <= 3'h2;
          end else begin
            state_reg <= S_CMD;
            lanes_reg <= quad_reg ? 3'h4 : 3'h1;
          end
        end
        S_CMD: if (go_rise) begin
          sh_reg  <= sh_next;
          cnt_reg <= cnt_step;
          if (cnt_step == CMD_BITS) begin
            cnt_reg <= 6'h00;
            op_reg  <= sh_next[7:0];
            if (write_in_progress_flag || !sfr_supported(sh_next[7:0], quad_reg)) begin
              state_reg <= S_SKIP;
            end else begin
              state_reg <= S_ADDR;
              lanes_reg <= sfr_lanes(sh_next[7:0], quad_reg);
              a4_reg    <= sfr_addr4(sh_next[7:0], quad_reg, ext_reg);
              if (sh_next[7:0] == OP_NORM || sh_next[7:0] == OP_NORM4)
                dum_reg <= 4'h0;
              else if (quad_reg)
                dum_reg <= dummy_quad;
              else if (sh_next[7:0] == OP_DIO || sh_next[7:0] == OP_DIO4)
                dum_reg <= dummy_dual;
              else
                dum_reg <= dummy_fast;
            end
          end
        end
        S_ADDR: if (go_rise) begin
          sh_reg  <= sh_next;
          cnt_reg <= cnt_step;
          if (cnt_step == (a4_reg ? ADDR4_BITS : ADDR3_BITS)) begin
            cnt_reg   <= 6'h00;
            addr_reg  <= a4_reg ? sh_next[26:0] : {3'h0, sh_next[23:0]};
            state_reg <= (dum_reg == 4'h0) ? S_DATA : S_DUMMY;
          end
        end
        S_DUMMY: if (go_rise) begin
          cnt_reg <= cnt_reg + 6'h01;
          if (dio && cnt_reg < MODE_CYC)
            mode_reg <= mode_next;
          if (dio && cnt_reg == MODE_CYC - 6'h01)
            cont_reg <= (mode_next[7:4] == CONT_NIBBLE);
          if (cnt_reg + 6'h01 == {2'h0, dum_reg})
            state_reg <= S_DATA;
        end
        S_DATA: begin
          if (go_fall && dcnt_reg == 3'h0)
            addr_reg <= addr_reg + 27'h000_0001;
        end
        S_SKIP: begin
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // data output shifter
  // ----------------------------------------
  // bits change on falling sck, lines released when paused or deselected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dsh_reg     <= 8'h00;
      dcnt_reg    <= 3'h0;
      started_reg <= 1'b0;
      out_reg     <= 4'h0;
      oe_reg      <= 4'h0;
    end else if (!sel || state_reg != S_DATA) begin
      dcnt_reg    <= 3'h0;
      started_reg <= 1'b0;
      oe_reg      <= 4'h0;
    end else begin
      oe_reg <= ((started_reg || go_fall) && !paused_reg) ? lane_mask : 4'h0;
      if (go_fall) begin
        started_reg <= 1'b1;
        dsh_reg     <= 8'(cur_byte << lanes_reg);
        dcnt_reg    <= dcnt_reg + lanes_reg;
        if (lanes_reg == 3'h1)
          out_reg <= {2'h0, cur_byte[7], 1'b0};
        else if (lanes_reg == 3'h2)
          out_reg <= {2'h0, cur_byte[7:6]};
        else
          out_reg <= cur_byte[7:4];
      end
    end
  end

  assign bus.d_o   = out_reg;
  assign bus.d_oe  = oe_reg;
  assign mem_addr  = addr_reg;
  assign cont_read = cont_reg;
  assign busy      = state_reg != S_IDLE;

endmodule

/* sfr_host.sv */
/*
  Host end of the read engine: takes orders over Avalon-MM registers,
  makes sck from clock by a divider and runs one read per start.
  Assumes the flash device on the link and its settings matching CFG.
*/
`timescale 1ns/10ps
module sfr_host
  import sfr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  sfr_if.host              bus
);

  sfr_state_t  state_reg;
  logic [31:0] cfg_reg;
  logic [31:0] addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_reg;
  logic        ack_reg;
  logic        hold_req_reg;
  logic        hold_n_reg;
  logic        sck_reg;
  logic        cs_n_reg;
  logic [3:0]  div_reg;
  logic [31:0] out_reg;
  logic        drv_reg;
  logic [2:0]  w_reg;
  logic [5:0]  cnt_reg;
  logic [10:0] rcnt_reg;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic        wr_en;
  logic        go;
  logic        run;
  logic        tick;
  logic [7:0]  op;
  logic        quad;
  logic        a4;
  logic        dio;
  logic [3:0]  dum;
  logic [5:0]  cnt_step;
  logic [3:0]  din;

  assign op    = cfg_reg[7:0];
  assign quad  = cfg_reg[CFG_QUAD];
  assign dum   = cfg_reg[CFG_DUM +: 4];
  assign a4    = sfr_addr4(op, quad, cfg_reg[CFG_EXT]);
  assign dio   = (op == OP_DIO) || (op == OP_DIO4);
  assign wr_en = avs_write && ack_reg;
  assign go    = wr_en && avs_address == REG_CTRL && avs_writedata[CTRL_GO] && state_reg == S_IDLE;
  assign run   = state_reg != S_IDLE && hold_n_reg && !(hold_req_reg && !sck_reg);
  assign tick  = run && div_reg == SCK_HALF_CYC - 4'h1;
  assign cnt_step = cnt_reg + {3'h0, w_reg};
  assign din   = (w_reg == 3'h1) ? {3'h0, io_s2[1]} : io_s2;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  // one wait cycle per access; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg      <= 1'b0;
      rd_reg       <= 32'h0000_0000;
      cfg_reg      <= CFG_RESET;
      addr_reg     <= 32'h0000_0000;
      hold_req_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (avs_read && !ack_reg) begin
        unique case (avs_address)
          REG_CFG:   rd_reg <= cfg_reg;
          REG_ADDR:  rd_reg <= addr_reg;
          REG_STAT:  rd_reg <= {30'h0000_0000, ~hold_n_reg, state_reg != S_IDLE};
          REG_RDATA: rd_reg <= rdata_reg;
          default:   rd_reg <= 32'h0000_0000;
        endcase
      end
      if (wr_en && avs_address == REG_CTRL)
        hold_req_reg <= avs_writedata[CTRL_HOLD];
      if (wr_en && avs_address == REG_CFG && state_reg == S_IDLE)
        cfg_reg <= avs_writedata;
      if (wr_en && avs_address == REG_ADDR && state_reg == S_IDLE)
        addr_reg <= avs_writedata;
    end
  end

  assign avs_readdata = rd_reg;

  // ----------------------------------------
  // input synchroniser, clock divider and pause pin
  // ----------------------------------------
  // pause only changes while sck is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_s1      <= 4'h0;
      io_s2      <= 4'h0;
      div_reg    <= 4'h0;
      hold_n_reg <= 1'b1;
    end else begin
      io_s1 <= bus.io;
      io_s2 <= io_s1;
      if (!sck_reg)
        hold_n_reg <= ~hold_req_reg;
      if (!run)
        div_reg <= 4'h0;
      else
        div_reg <= tick ? 4'h0 : div_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // read sequencer
  // ----------------------------------------
  // outputs change on falling ticks, data sampled on rising ticks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      out_reg   <= 32'h0000_0000;
      drv_reg   <= 1'b0;
      w_reg     <= 3'h1;
      cnt_reg   <= 6'h00;
      rcnt_reg  <= 11'h000;
      rdata_reg <= 32'h0000_0000;
    end else if (go) begin
      cs_n_reg <= 1'b0;
      sck_reg  <= 1'b0;
      drv_reg  <= 1'b1;
      cnt_reg  <= 6'h00;
      rcnt_reg <= 11'h000;
      if (cfg_reg[CFG_SKIP]) begin
        state_reg <= S_ADDR;
        w_reg     <= sfr_lanes(op, quad);
        out_reg   <= a4 ? addr_reg : {addr_reg[23:0], 8'h00};
      end else begin
        state_reg <= S_CMD;
        w_reg     <= quad ? 3'h4 : 3'h1;
        out_reg   <= {op, 24'h00_0000};
      end
    end else if (tick && !sck_reg) begin
      sck_reg <= 1'b1;
      if (state_reg == S_DATA) begin
        rdata_reg <= sfr_shift(rdata_reg, din, w_reg);
        rcnt_reg  <= rcnt_reg + {8'h00, w_reg};
      end
    end else if (tick) begin
      sck_reg <= 1'b0;
      out_reg <= 32'(out_reg << w_reg);
      cnt_reg <= cnt_step;
      unique case (state_reg)
        S_CMD: if (cnt_step == CMD_BITS) begin
          state_reg <= S_ADDR;
          cnt_reg   <= 6'h00;
          w_reg     <= sfr_lanes(op, quad);
          out_reg   <= a4 ? addr_reg : {addr_reg[23:0], 8'h00};
        end
        S_ADDR: if (cnt_step == (a4 ? ADDR4_BITS : ADDR3_BITS)) begin
          cnt_reg   <= 6'h00;
          state_reg <= (dum == 4'h0) ? S_DATA : S_DUMMY;
          drv_reg   <= dio && dum != 4'h0;
          out_reg   <= {cfg_reg[CFG_MODE +: 8], 24'h00_0000};
        end
        S_DUMMY: begin
          cnt_reg <= cnt_reg + 6'h01;
          drv_reg <= dio && (cnt_reg + 6'h01 < MODE_DRV);
          if (cnt_reg + 6'h01 == {2'h0, dum}) begin
            state_reg <= S_DATA;
            drv_reg   <= 1'b0;
          end
        end
        S_DATA: if (rcnt_reg >= {cfg_reg[CFG_NB +: 8], 3'h0}) begin
          state_reg <= S_IDLE;
          cs_n_reg  <= 1'b1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  assign bus.sck    = sck_reg;
  assign bus.cs_n   = cs_n_reg;
  assign bus.hold_n = hold_n_reg;
  assign bus.h_o    = (w_reg == 3'h1) ? {3'h0, out_reg[31]} :
                      ((w_reg == 3'h2) ? {2'h0, out_reg[31:30]} : out_reg[31:28]);
  assign bus.h_oe   = !drv_reg ? 4'h0 : ((w_reg == 3'h1) ? 4'h1 : ((w_reg == 3'h2) ? 4'h3 : 4'hF));

endmodule

/* sfr_monitor.sv */
/*
  Link checker for the flash read engine: watches both ends on the link.
  Assumes the plain link signals, the 40 MHz clock and its reset.
*/
`timescale 1ns/10ps
module sfr_monitor (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       hold_n,
  input wire logic [3:0] h_o,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_o,
  input wire logic [3:0] d_oe
);
  logic       sck_reg;
  logic [3:0] fall_reg;

  // ----
  // cycles since the last falling sck
  // ----
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg  <= 1'h0;
      fall_reg <= 4'hF;
    end else begin
      sck_reg  <= sck;
      fall_reg <= (sck_reg && !sck) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hF};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_no_contention: assert property ((h_oe & d_oe) == 4'h0)
    else $error("both ends drive one line");
  a_deselect_release: assert property (cs_n [*4] |-> d_oe == 4'h0)
    else $error("device drives while deselected");
  a_hold_enter: assert property ($fell(hold_n) |-> !sck)
    else $error("pause entered with sck high");
  a_hold_leave: assert property ($rose(hold_n) |-> !sck)
    else $error("pause left with sck high");
  a_dev_on_fall: assert property (($changed(d_o) && d_oe != 4'h0 && !cs_n) |-> fall_reg <= 4'h6)
    else $error("device output changed away from falling sck");
  a_dev_stable_high: assert property ((sck && $past(sck) && d_oe != 4'h0) |-> $stable(d_o))
    else $error("device output moved while sck high");
  a_host_on_fall: assert property (($changed(h_o) && h_oe != 4'h0 && !cs_n) |-> !sck)
    else $error("host line changed while sck high");
  a_lane_set: assert property (d_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("device drives an odd lane set");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n [*2])
    else $error("deselect gap too short");
  a_idle_sck: assert property (cs_n [*2] |-> !sck)
    else $error("sck runs outside a frame");

  c_frame: cover property ($fell(cs_n));
  c_quad: cover property (d_oe == 4'hF);
  c_dual: cover property (d_oe == 4'h3);
  c_pause: cover property ($fell(hold_n) && !cs_n);
endmodule

/* serial_flash_read_engine_bench.sv */
/*
  Bench for the flash read engine: host and device joined by the link.
  Assumes the host register map of the package and a bench byte array.
*/
`timescale 1ns/10ps
module serial_flash_read_engine_bench
  import sfr_pkg::*;
;
  logic        clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        write_in_progress_flag, ext_addr_in, quad_mode_in, qe, dtr, hpr, cont_read, busy;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [26:0] mem_addr;
  logic [7:0]  mem_rdata;
  int          n_errors, total_checks;
  // rows: opcode, {quad, ext}, mode byte, address as sent
  logic [51:0] rows [13] = '{52'h03_0_00_00123456, 52'h03_1_00_F9123456, 52'h13_0_00_07FFFFFE,
    52'h0B_0_00_00ABCDEF, 52'h0C_1_00_0A5A5A5A, 52'h0B_3_00_03000010, 52'h0C_2_00_00400020,
    52'hEB_2_00_00654321, 52'h4B_3_00_00111111, 52'h68_3_00_00222222, 52'hBB_1_00_04000030,
    52'hBC_0_00_05000040, 52'hBB_0_50_00334455};

  // ----
  // byte array, link and both ends
  // ----
  function automatic logic [7:0] mb(input logic [26:0] a);
    return a[7:0] ^ a[23:16] ^ {a[26:24], 5'h00};
  endfunction
  function automatic logic [31:0] mw(input logic [26:0] a);
    return {mb(a), mb(a + 27'h1), mb(a + 27'h2), mb(a + 27'h3)};
  endfunction
  function automatic logic [26:0] ea(input logic [51:0] r);
    logic w4;
    w4 = r[51:44] inside {OP_NORM4, OP_FAST4, OP_DIO4} || (r[40] && !(r[41] && r[51:44] inside {OP_UID, OP_IROW}));
    return w4 ? r[26:0] : {3'h0, r[23:0]};
  endfunction
  assign mem_rdata = mb(mem_addr);
  always #12.5 clock = ~clock;
  sfr_if link();
  sfr_host sfr_host_inst (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus(link));
  sfr_dev sfr_dev_inst (.clock(clock), .rst_n(rst_n), .bus(link), .write_in_progress_flag(write_in_progress_flag), .ext_addr_in(ext_addr_in),
    .quad_mode_in(quad_mode_in), .qe(qe), .dtr_mode(dtr), .hold_pin_reset(hpr), .dummy_fast(DUM_FAST),
    .dummy_quad(DUM_QUAD), .dummy_dual(DUM_DUAL), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .cont_read(cont_read), .busy(busy));
  sfr_monitor sfr_monitor_inst (.clock(clock), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
    .hold_n(link.hold_n), .h_o(link.h_o), .h_oe(link.h_oe), .d_o(link.d_o), .d_oe(link.d_oe));

  // ----
  // report, compare and bus tasks
  // ----
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 3000) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // request stands until an edge samples waitrequest low; data taken there
    do begin
      @(posedge clock);
      n++;
      tmo(n * 100);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic go(input logic [7:0] op, input logic q, input logic e, input logic k, input logic [7:0] md,
                    input logic [31:0] a);
    logic [31:0] x;
    logic [3:0]  dm;
    dm = op inside {OP_NORM, OP_NORM4} ? 4'h0 : q ? DUM_QUAD : op inside {OP_DIO, OP_DIO4} ? DUM_DUAL : DUM_FAST;
    quad_mode_in <= q;
    ext_addr_in  <= e;
    av(1'h1, REG_CFG, {8'h04, md, dm, 1'h0, k, e, q, op}, x);
    av(1'h1, REG_ADDR, a, x);
    av(1'h1, REG_CTRL, 32'h1, x);
  endtask
  task automatic fin(input logic [31:0] ew);
    logic [31:0] x;
    int n;
    n = 0;
    x = 32'h1;
    while (x[0] !== 1'h0) begin
      av(1'h0, REG_STAT, 32'h0, x);
      n++;
      tmo(n);
    end
    av(1'h0, REG_RDATA, 32'h0, x);
    chk("read data", ew, x);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] x;
    clock = 1'h0;
    rst_n = 1'h0;
    {avs_read, avs_write, write_in_progress_flag, ext_addr_in, quad_mode_in, qe, dtr, hpr} = 8'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clock);
    chk("idle select", 32'h1, {31'h0, link.cs_n});
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    av(1'h0, REG_CFG, 32'h0, x);
    chk("config reset", CFG_RESET, x);
    av(1'h0, 5'h14, 32'h0, x);
    chk("unmapped read", 32'h0, x);
    chk("continuous reset", 32'h0, {31'h0, cont_read});
    for (int i = 0; i < 13; i++) begin
      go(rows[i][51:44], rows[i][41], rows[i][40], 1'h0, rows[i][39:32], rows[i][31:0]);
      fin(mw(ea(rows[i])));
    end
    go(OP_NORM, 1'h0, 1'h0, 1'h0, 8'h00, 32'h00000777);
    fin(mw(27'h0000777));
    go(OP_DIO, 1'h0, 1'h0, 1'h0, 8'hA5, 32'h00010203);
    fin(mw(27'h0010203));
    chk("continuous armed", 32'h1, {31'h0, cont_read});
    go(OP_DIO, 1'h0, 1'h0, 1'h1, 8'h50, 32'h02000004);
    fin(mw(27'h0000004));
    chk("continuous left", 32'h0, {31'h0, cont_read});
    write_in_progress_flag <= 1'h1;
    go(OP_FAST, 1'h0, 1'h0, 1'h0, 8'h00, 32'h00000100);
    fin(32'hFFFF_FFFF);
    write_in_progress_flag <= 1'h0;
    // pause in mid data, plainly and with each pause-disabling setting
    for (int j = 0; j < 4; j++) begin
      qe  <= (j == 1);
      dtr <= (j == 2);
      hpr <= (j == 3);
      go(OP_FAST, 1'h0, 1'h0, 1'h0, 8'h00, 32'h00000800);
      repeat (900) @(posedge clock);
      av(1'h1, REG_CTRL, 32'h2, x);
      repeat (100) @(posedge clock);
      chk("paused enables", (j != 0) ? 32'h2 : 32'h0, {28'h0, link.d_oe});
      av(1'h0, REG_STAT, 32'h0, x);
      chk("pause status", 32'h3, x);
      av(1'h1, REG_CTRL, 32'h0, x);
      fin(mw(27'h0000800));
    end
    {qe, dtr, hpr} <= 3'h0;
    // reset in mid read, then a read after it
    go(OP_FAST, 1'h0, 1'h0, 1'h0, 8'h00, 32'h00000900);
    repeat (900) @(posedge clock);
    rst_n <= 1'h0;
    repeat (16) @(posedge clock);
    chk("reset state", 32'h1, {29'h0, busy, cont_read, link.cs_n});
    chk("reset enables", 32'h0, {28'h0, link.d_oe});
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    go(OP_NORM, 1'h0, 1'h0, 1'h0, 8'h00, 32'h00000123);
    fin(mw(27'h0000123));
    chk("device idle", 32'h0, {31'h0, busy});
    conclude();
  end
endmodule
